// ==== verilog/smls_top.sv ====
/*
  Torque/position dual-mode selector with speed and torque limit gating and
  two analog monitor channels. Assumes digital inputs arrive asynchronously
  from a motion controller; analog values and pulse counts are on core_clk_i.
*/
// How it works
// - With torque/position select high the block runs torque mode, picks torque by its select pins, ignores the trigger.
// - With the select low the position command is undetermined and the motor is held until a trigger rising edge.
// - A trigger rising edge in position mode latches the index inputs and starts the move at once.
// - Raising the select again returns to torque mode at once, no trigger needed.
// - Pulse-torque mode takes position from the pulse input, preset-torque mode from the stored table.
// - Speed limit applies only in torque mode and only while its enable bit is 1.
// - Speed limit value is chosen like a speed command: preset by the select inputs, else analog input.
// - Torque limit applies only in position mode and only while its enable bit is 1.
// - Torque select inputs pick the torque limit preset only while the limit is enabled.
// - Each channel scales its source maximum to 8 V; pulse rate to 4.5 Mpps, bus voltage to 450 V.
// - The analog polarity digit inverts channel 2 on 1, channel 1 on 2, both on 3.
// - The pulse polarity digit sets one polarity, forward or reverse, for all pulse outputs.
// - Each channel is multiplied by its own proportion setting, capped at 100, over 100, default 100.
// - Each channel is clamped to plus or minus 8 V in a 10-bit code.
`timescale 1ns/1ps
module smls_top
  import smls_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire smls_pins_t pins_i,
  input wire logic [15:0] pulse_pos_i,
  input wire logic signed [15:0] analog_speed_i,
  input wire logic signed [15:0] analog_torque_i,
  input wire logic signed [15:0] motor_speed_i,
  input wire logic signed [15:0] motor_torque_i,
  input wire logic [15:0] pulse_freq_i,
  input wire logic [15:0] bus_volt_i,
  input wire logic pulse_a_i,
  input wire logic pulse_b_i,
  output logic torque_mode_o,
  output logic motor_hold_o,
  output logic [15:0] position_cmd_o,
  output logic signed [15:0] torque_cmd_o,
  output logic speed_limit_en_o,
  output logic [15:0] speed_limit_o,
  output logic torque_limit_en_o,
  output logic [15:0] torque_limit_o,
  output logic signed [MON_W-1:0] probe_ch1_o,
  output logic signed [MON_W-1:0] probe_ch2_o,
  output logic pulse_a_o,
  output logic pulse_b_o
);
  logic [PIN_W-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
  smls_pins_t pins_f;
  logic trig_prev_reg;
  logic trig_rise;
  smls_state_t state_reg, state_next;
  logic [5:0] pos_index_reg;
  logic [15:0] monitor_source_select_reg;
  logic [15:0] output_polarity_config_reg;
  logic [15:0] monitor_ch1_gain_reg;
  logic [15:0] monitor_ch2_gain_reg;
  logic [15:0] mode_ctrl_reg;
  logic [15:0] limit_enable_param_reg;
  logic [15:0] max_speed_param_reg;
  logic [5:0] table_index_reg;
  logic [15:0] spd_preset_reg [PRESETS];
  logic [15:0] trq_preset_reg [PRESETS];
  logic [15:0] pos_table [POS_ENTRIES];
  logic signed [15:0] speed_sel, torque_sel;
  logic [15:0] rdata_next;
  smls_mon_src_t mon_src;

  // Three-stage pin synchroniser; a change counts once stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          filt_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins_i[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            filt_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate
  assign pins_f = smls_pins_t'(filt_reg);

  // Trigger edge detector on the filtered pin.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= pins_f.position_trigger;
    end
  end
  assign trig_rise = pins_f.position_trigger & ~trig_prev_reg;

  // Mode state: torque while select is high, wait then run in position mode.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_TORQUE: begin
        if (!pins_f.torque_pos_sel) begin
          state_next = ST_POS_WAIT;
        end
      end
      ST_POS_WAIT, ST_POS_RUN: begin
        if (pins_f.torque_pos_sel) begin
          state_next = ST_TORQUE;
        end else if (trig_rise) begin
          state_next = ST_POS_RUN;
        end
      end
      default: begin
        state_next = ST_TORQUE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_TORQUE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Index latch; the trigger is ignored while torque mode is selected.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pos_index_reg <= '0;
    end else if (state_reg != ST_TORQUE && !pins_f.torque_pos_sel && trig_rise) begin
      pos_index_reg <= pins_f.position_index_select;
    end
  end

  assign torque_mode_o = (state_reg == ST_TORQUE);
  assign motor_hold_o = (state_reg == ST_POS_WAIT);

  // Command picks: select 0 takes the analog input, 1 to 3 take a preset.
  always_comb begin
    if (pins_f.speed_cmd_select == 2'h0) begin
      speed_sel = analog_speed_i;
    end else begin
      speed_sel = $signed(spd_preset_reg[pins_f.speed_cmd_select - 2'h1]);
    end
    if (pins_f.torque_cmd_select == 2'h0) begin
      torque_sel = analog_torque_i;
    end else begin
      torque_sel = $signed(trq_preset_reg[pins_f.torque_cmd_select - 2'h1]);
    end
  end

  // Registered commands and limits.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      position_cmd_o <= '0;
      torque_cmd_o <= '0;
      speed_limit_en_o <= 1'b0;
      speed_limit_o <= '0;
      torque_limit_en_o <= 1'b0;
      torque_limit_o <= '0;
    end else begin
      if (state_reg == ST_POS_RUN) begin
        position_cmd_o <= mode_ctrl_reg[MODE_PRESET_BIT] ? pos_table[pos_index_reg]
                                                         : pulse_pos_i;
      end
      torque_cmd_o <= (state_reg == ST_TORQUE) ? torque_sel : 16'sh0000;
      speed_limit_en_o <= (state_reg == ST_TORQUE) &&
                          limit_enable_param_reg[LIM_SPD_BIT];
      speed_limit_o <= ($unsigned(speed_sel) > max_speed_param_reg) ? max_speed_param_reg
                                                                     : $unsigned(speed_sel);
      torque_limit_en_o <= (state_reg != ST_TORQUE) &&
                           limit_enable_param_reg[LIM_TRQ_BIT];
      torque_limit_o <= limit_enable_param_reg[LIM_TRQ_BIT] ? $unsigned(torque_sel)
                                                            : 16'h0000;
    end
  end

  // Pulse outputs: reverse polarity swaps the two phases on every output.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pulse_a_o <= 1'b0;
      pulse_b_o <= 1'b0;
    end else if (output_polarity_config_reg[POL_PULSE_BIT]) begin
      pulse_a_o <= pulse_b_i;
      pulse_b_o <= pulse_a_i;
    end else begin
      pulse_a_o <= pulse_a_i;
      pulse_b_o <= pulse_b_i;
    end
  end

  // Fixed-offset configuration registers.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      monitor_source_select_reg <= MON_SRC_RST;
      output_polarity_config_reg <= POLARITY_RST;
      monitor_ch1_gain_reg <= GAIN_RST;
      monitor_ch2_gain_reg <= GAIN_RST;
      mode_ctrl_reg <= MODE_RST;
      limit_enable_param_reg <= LIMIT_EN_RST;
      max_speed_param_reg <= MAX_SPEED_RST;
      table_index_reg <= '0;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_MON_SRC: monitor_source_select_reg <= wdata_i;
        ADDR_POLARITY: output_polarity_config_reg <= wdata_i;
        ADDR_CH1_GAIN: monitor_ch1_gain_reg <= wdata_i;
        ADDR_CH2_GAIN: monitor_ch2_gain_reg <= wdata_i;
        ADDR_MODE_CTRL: mode_ctrl_reg <= wdata_i;
        ADDR_LIMIT_EN: limit_enable_param_reg <= wdata_i;
        ADDR_MAX_SPEED: max_speed_param_reg <= wdata_i;
        ADDR_POS_INDEX: table_index_reg <= wdata_i[5:0];
        default: begin
        end
      endcase
    end
  end

  // Preset registers, one per nonzero select value.
  generate
    for (gi = 0; gi < PRESETS; gi++) begin : g_preset
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          spd_preset_reg[gi] <= PRESET_RST;
          trq_preset_reg[gi] <= PRESET_RST;
        end else if (wr_i) begin
          if (addr_i == ADDR_SPD_PRESET0 + 16'(gi) * ADDR_STEP) begin
            spd_preset_reg[gi] <= wdata_i;
          end
          if (addr_i == ADDR_TRQ_PRESET0 + 16'(gi) * ADDR_STEP) begin
            trq_preset_reg[gi] <= wdata_i;
          end
        end
      end
    end
  endgenerate

  // Stored position table, written at the current table index.
  always_ff @(posedge core_clk_i) begin
    if (wr_i && addr_i == ADDR_POS_DATA) begin
      pos_table[table_index_reg] <= wdata_i;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_next = 16'h0000;
    case (addr_i)
      ADDR_MON_SRC: rdata_next = monitor_source_select_reg;
      ADDR_POLARITY: rdata_next = output_polarity_config_reg;
      ADDR_CH1_GAIN: rdata_next = monitor_ch1_gain_reg;
      ADDR_CH2_GAIN: rdata_next = monitor_ch2_gain_reg;
      ADDR_MODE_CTRL: rdata_next = mode_ctrl_reg;
      ADDR_LIMIT_EN: rdata_next = limit_enable_param_reg;
      ADDR_MAX_SPEED: rdata_next = max_speed_param_reg;
      ADDR_POS_INDEX: rdata_next = {10'h000, table_index_reg};
      ADDR_POS_DATA: rdata_next = pos_table[table_index_reg];
      ADDR_STATUS: rdata_next = {6'h00, pos_index_reg, 2'h0, state_reg};
      ADDR_SPD_PRESET0: rdata_next = spd_preset_reg[0];
      ADDR_SPD_PRESET0 + ADDR_STEP: rdata_next = spd_preset_reg[1];
      ADDR_SPD_PRESET0 + 16'h0004: rdata_next = spd_preset_reg[2];
      ADDR_TRQ_PRESET0: rdata_next = trq_preset_reg[0];
      ADDR_TRQ_PRESET0 + ADDR_STEP: rdata_next = trq_preset_reg[1];
      ADDR_TRQ_PRESET0 + 16'h0004: rdata_next = trq_preset_reg[2];
      default: rdata_next = 16'h0000;
    endcase
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !rd_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  // Monitor channels.
  assign mon_src = '{motor_speed: motor_speed_i, motor_torque: motor_torque_i,
                     pulse_freq_kpps: pulse_freq_i, speed_cmd: speed_sel,
                     torque_cmd: torque_cmd_o, bus_volt: bus_volt_i};

  smls_mon_chan u_ch1 (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .src_i(mon_src),
    .code_i(monitor_source_select_reg[MON_CH1_LSB +: 3]),
    .gain_i(monitor_ch1_gain_reg),
    .invert_i(output_polarity_config_reg[POL_MON_LSB + 1]),
    .mon_o(probe_ch1_o)
  );

  smls_mon_chan u_ch2 (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .src_i(mon_src),
    .code_i(monitor_source_select_reg[MON_CH2_LSB +: 3]),
    .gain_i(monitor_ch2_gain_reg),
    .invert_i(output_polarity_config_reg[POL_MON_LSB]),
    .mon_o(probe_ch2_o)
  );

  // Checks on the mode, limit and monitor behaviour.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  trig_ignored_a: assert property (pins_f.torque_pos_sel |=> torque_mode_o)
    else $error("Trigger or wait state seen while torque select high.");
  hold_wait_a: assert property ((state_reg == ST_TORQUE) && !pins_f.torque_pos_sel
      ##1 !trig_rise && !pins_f.torque_pos_sel |=> motor_hold_o)
    else $error("Motor not held while waiting for trigger.");
  index_latch_a: assert property ((state_reg != ST_TORQUE) && !pins_f.torque_pos_sel && trig_rise
      |=> state_reg == ST_POS_RUN && pos_index_reg == $past(pins_f.position_index_select))
    else $error("Index not latched on trigger edge.");
  torque_return_a: assert property ((state_reg != ST_TORQUE) && pins_f.torque_pos_sel
      |=> state_reg == ST_TORQUE)
    else $error("No immediate return to torque mode.");
  preset_source_a: assert property ((state_reg == ST_POS_RUN) && mode_ctrl_reg[MODE_PRESET_BIT]
      |=> position_cmd_o == $past(pos_table[pos_index_reg]))
    else $error("Preset position command not from table.");
  speed_gate_a: assert property (speed_limit_en_o |-> $past(limit_enable_param_reg[LIM_SPD_BIT])
      && $past(state_reg) == ST_TORQUE)
    else $error("Speed limit active outside torque mode or disabled.");
  torque_gate_a: assert property (torque_limit_en_o |-> $past(limit_enable_param_reg[LIM_TRQ_BIT])
      && $past(state_reg) != ST_TORQUE)
    else $error("Torque limit active in torque mode or disabled.");
  limit_off_a: assert property (!limit_enable_param_reg[LIM_TRQ_BIT]
      |=> torque_limit_o == 16'h0000)
    else $error("Torque limit value follows select while disabled.");
  mon_clamp_a: assert property (probe_ch1_o >= -MON_FS && probe_ch2_o >= -MON_FS)
    else $error("Monitor output below negative full scale.");
  mon_reserved_a: assert property (monitor_source_select_reg[MON_CH1_LSB +: 3] > SRC_BUS
      |=> probe_ch1_o == 0)
    else $error("Reserved source gave nonzero monitor output.");
  pulse_swap_a: assert property (output_polarity_config_reg[POL_PULSE_BIT]
      |=> pulse_a_o == $past(pulse_b_i) && pulse_b_o == $past(pulse_a_i))
    else $error("Reverse pulse polarity not applied.");

  run_seen_c: cover property ((state_reg == ST_POS_WAIT) ##1 (state_reg == ST_POS_RUN));
  back_torque_c: cover property ((state_reg == ST_POS_RUN) ##1 (state_reg == ST_TORQUE));
  spd_limit_c: cover property (speed_limit_en_o && pins_f.speed_cmd_select != 2'h0);
  mon_clip_c: cover property (probe_ch1_o == MON_FS);
endmodule

// ==== verilog/smls_pkg.sv ====
/*
  Shared constants and types for the servo mode, limit and monitor selector.
  Assumes one 40 MHz clock and a plain 16-bit register port at printed offsets.
*/
package smls_pkg;
  // Register offsets, used as byte addresses on the register port.
  localparam logic [15:0] ADDR_MON_SRC = 16'h0006;
  localparam logic [15:0] ADDR_POLARITY = 16'h0106;
  localparam logic [15:0] ADDR_CH1_GAIN = 16'h0108;
  localparam logic [15:0] ADDR_CH2_GAIN = 16'h010A;
  localparam logic [15:0] ADDR_MODE_CTRL = 16'h0100;
  localparam logic [15:0] ADDR_LIMIT_EN = 16'h0104;
  localparam logic [15:0] ADDR_SPD_PRESET0 = 16'h0112;
  localparam logic [15:0] ADDR_TRQ_PRESET0 = 16'h0118;
  localparam logic [15:0] ADDR_MAX_SPEED = 16'h016E;
  localparam logic [15:0] ADDR_POS_INDEX = 16'h0200;
  localparam logic [15:0] ADDR_POS_DATA = 16'h0202;
  localparam logic [15:0] ADDR_STATUS = 16'h0300;
  localparam logic [15:0] ADDR_STEP = 16'h0002;

  // Reset values.
  localparam logic [15:0] MON_SRC_RST = 16'h0001;
  localparam logic [15:0] POLARITY_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'h0064;
  localparam logic [15:0] LIMIT_EN_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] MAX_SPEED_RST = 16'h7FFF;
  localparam logic [15:0] PRESET_RST = 16'h0000;

  // Field positions.
  localparam int MON_CH1_LSB = 4;
  localparam int MON_CH2_LSB = 0;
  localparam int POL_MON_LSB = 0;
  localparam int POL_PULSE_BIT = 4;
  localparam int LIM_SPD_BIT = 0;
  localparam int LIM_TRQ_BIT = 4;
  localparam int MODE_PRESET_BIT = 0;

  // Monitor scaling: 10-bit signed code, 511 codes stand for 8 V.
  localparam int MON_W = 10;
  localparam int MON_FS = 511;
  localparam int SRC_FULL = 32767;
  localparam int PULSE_FULL_KPPS = 4500;
  localparam int BUS_FULL_V = 450;
  localparam int GAIN_DIV = 100;
  localparam logic [15:0] GAIN_MAX = 16'h0064;

  // Monitor source codes.
  localparam logic [2:0] SRC_SPEED = 3'h0;
  localparam logic [2:0] SRC_TORQUE = 3'h1;
  localparam logic [2:0] SRC_PULSE = 3'h2;
  localparam logic [2:0] SRC_SPD_CMD = 3'h3;
  localparam logic [2:0] SRC_TRQ_CMD = 3'h4;
  localparam logic [2:0] SRC_BUS = 3'h5;

  localparam int PRESETS = 3;
  localparam int POS_ENTRIES = 64;
  localparam int PIN_W = 12;

  // Position control states, Gray coded along torque, wait, run.
  typedef enum logic [1:0] {
    ST_TORQUE = 2'b00,
    ST_POS_WAIT = 2'b01,
    ST_POS_RUN = 2'b11
  } smls_state_t;

  // Digital inputs from the motion controller.
  typedef struct packed {
    logic torque_pos_sel;
    logic position_trigger;
    logic [5:0] position_index_select;
    logic [1:0] torque_cmd_select;
    logic [1:0] speed_cmd_select;
  } smls_pins_t;

  // Quantities that the monitors can show.
  typedef struct packed {
    logic signed [15:0] motor_speed;
    logic signed [15:0] motor_torque;
    logic [15:0] pulse_freq_kpps;
    logic signed [15:0] speed_cmd;
    logic signed [15:0] torque_cmd;
    logic [15:0] bus_volt;
  } smls_mon_src_t;
endpackage

// ==== verilog/smls_mon_chan.sv ====
/*
  One analog monitor channel: source pick, scaling, proportion, clamp, polarity.
  Assumes source values settle in the same clock domain; output is registered.
*/
`timescale 1ns/1ps
module smls_mon_chan
  import smls_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire smls_mon_src_t src_i,
  input wire logic [2:0] code_i,
  input wire logic [15:0] gain_i,
  input wire logic invert_i,
  output logic signed [MON_W-1:0] mon_o
);
  logic signed [31:0] raw;
  logic signed [31:0] full;
  logic signed [31:0] scaled;
  logic signed [31:0] gained;
  logic signed [31:0] clamped;
  logic [15:0] gain_eff;

  // Pick the source and its full-scale figure; reserved codes give zero.
  always_comb begin
    raw = 32'sh0000_0000;
    full = 32'sh0000_0001;
    case (code_i)
      SRC_SPEED: begin
        raw = 32'(src_i.motor_speed);
        full = SRC_FULL;
      end
      SRC_TORQUE: begin
        raw = 32'(src_i.motor_torque);
        full = SRC_FULL;
      end
      SRC_PULSE: begin
        raw = $signed({16'h0000, src_i.pulse_freq_kpps});
        full = PULSE_FULL_KPPS;
      end
      SRC_SPD_CMD: begin
        raw = 32'(src_i.speed_cmd);
        full = SRC_FULL;
      end
      SRC_TRQ_CMD: begin
        raw = 32'(src_i.torque_cmd);
        full = SRC_FULL;
      end
      SRC_BUS: begin
        raw = $signed({16'h0000, src_i.bus_volt});
        full = BUS_FULL_V;
      end
      default: begin
        raw = 32'sh0000_0000;
        full = 32'sh0000_0001;
      end
    endcase
  end

  // Scale to 8 V, apply the proportion, then clamp to the 10-bit range.
  always_comb begin
    gain_eff = (gain_i > GAIN_MAX) ? GAIN_MAX : gain_i;
    scaled = (raw * MON_FS) / full;
    gained = (scaled * $signed({16'h0000, gain_eff})) / GAIN_DIV;
    if (gained > MON_FS) begin
      clamped = MON_FS;
    end else if (gained < -MON_FS) begin
      clamped = -MON_FS;
    end else begin
      clamped = gained;
    end
  end

  // Register the code, inverted when the channel polarity says so.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mon_o <= '0;
    end else if (invert_i) begin
      mon_o <= MON_W'(-clamped);
    end else begin
      mon_o <= MON_W'(clamped);
    end
  end
endmodule

// ==== verif/smls_motion_ctrl.sv ====
/*
  Behavioural motion controller that drives the selector's digital inputs and pulses.
  Assumes the selector samples its pins on core_clk_i through a four-edge filter.
*/
`timescale 1ns/1ps
module smls_motion_ctrl
  import smls_pkg::*;
(
  input wire logic core_clk_i,
  output smls_pins_t pins_o,
  output logic [15:0] pulse_pos_o,
  output logic pulse_a_o,
  output logic pulse_b_o
);
  // Pulse counter and phase levels hold still for the whole run.
  initial begin
    pins_o = '0;
    pulse_pos_o = 16'h0ABC;
    pulse_a_o = 1'b1;
    pulse_b_o = 1'b0;
  end

  // Sets select, index and command pins, then lets the filter settle.
  task automatic drive(input logic sel, input logic [5:0] idx, input logic [1:0] tcm,
                       input logic [1:0] spd);
    @(posedge core_clk_i);
    pins_o <= {sel, 1'b0, idx, tcm, spd};
    repeat (8) @(posedge core_clk_i);
  endtask

  // Raises the trigger long enough to pass the filter, then drops it.
  task automatic fire();
    @(posedge core_clk_i);
    pins_o.position_trigger <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    pins_o.position_trigger <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask
endmodule

// ==== verif/servo_mode_limit_monitor_select_bench.sv ====
/*
  Self-checking bench for the mode, limit and monitor selector.
  Assumes a 40 MHz clock, synchronous reset and a one-cycle read port.
*/
`timescale 1ns/1ps
module servo_mode_limit_monitor_select_bench;
  import smls_pkg::*;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] addr_i = '0;
  logic [15:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic signed [15:0] an_spd = 16'sd1000;
  logic signed [15:0] an_trq = -16'sd32767;
  logic signed [15:0] mot_spd = 16'sd32767;
  logic signed [15:0] mot_trq = -16'sd16384;
  logic [15:0] p_freq = 16'd2250;
  logic [15:0] bus_v = 16'd900;
  logic [15:0] rdata_o, position_cmd_o, speed_limit_o, torque_limit_o, pulse_pos;
  logic signed [15:0] torque_cmd_o;
  logic torque_mode_o, motor_hold_o, speed_limit_en_o, torque_limit_en_o;
  logic pulse_a, pulse_b, pulse_a_o, pulse_b_o;
  logic signed [MON_W-1:0] probe_ch1_o, probe_ch2_o;
  logic signed [MON_W-1:0] exp_mon [8];
  smls_pins_t pins;
  int err_total = 0;
  int tests_run = 0;

  // Clock at 25 ns period.
  always #12.5 core_clk_i = ~core_clk_i;

  smls_motion_ctrl ctrl (.core_clk_i(core_clk_i), .pins_o(pins), .pulse_pos_o(pulse_pos),
    .pulse_a_o(pulse_a), .pulse_b_o(pulse_b));

  smls_top uut (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_i(pins),
    .pulse_pos_i(pulse_pos), .analog_speed_i(an_spd), .analog_torque_i(an_trq),
    .motor_speed_i(mot_spd), .motor_torque_i(mot_trq), .pulse_freq_i(p_freq),
    .bus_volt_i(bus_v), .pulse_a_i(pulse_a), .pulse_b_i(pulse_b),
    .torque_mode_o(torque_mode_o), .motor_hold_o(motor_hold_o),
    .position_cmd_o(position_cmd_o), .torque_cmd_o(torque_cmd_o),
    .speed_limit_en_o(speed_limit_en_o), .speed_limit_o(speed_limit_o),
    .torque_limit_en_o(torque_limit_en_o), .torque_limit_o(torque_limit_o),
    .probe_ch1_o(probe_ch1_o), .probe_ch2_o(probe_ch2_o), .pulse_a_o(pulse_a_o),
    .pulse_b_o(pulse_b_o));

  // Word and flag comparison.
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Monitor code comparison.
  task automatic chk_m(input logic signed [MON_W-1:0] g, input logic signed [MON_W-1:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: monitor %0d expected %0d", $time, g, e);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  // One-cycle read; data is looked at in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk_w(rdata_o, e);
  endtask

  // Lets registered outputs settle before sampling.
  task automatic settle();
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    exp_mon = '{10'sd511, -10'sd255, 10'sd255, 10'sd3, -10'sd511, 10'sd511, 10'sd0, 10'sd0};
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(ADDR_MON_SRC, MON_SRC_RST);
    rd(ADDR_POLARITY, POLARITY_RST);
    rd(ADDR_CH1_GAIN, GAIN_RST);
    rd(ADDR_CH2_GAIN, GAIN_RST);
    rd(16'h0400, 16'h0000);
    settle();
    chk_w(motor_hold_o, 16'h0001);
    wr(ADDR_LIMIT_EN, 16'h0011);
    wr(ADDR_SPD_PRESET0, 16'h0100);
    wr(16'h011A, 16'h0200);
    ctrl.drive(1'b1, 6'h00, 2'h0, 2'h1);
    #1 chk_w({torque_mode_o, motor_hold_o}, 16'h0002);
    chk_w(torque_cmd_o, an_trq);
    chk_w(speed_limit_en_o, 16'h0001);
    chk_w(speed_limit_o, 16'h0100);
    chk_w(torque_limit_en_o, 16'h0000);
    ctrl.fire();
    #1 chk_w({torque_mode_o, motor_hold_o}, 16'h0002);
    // Every source code on channel 1, channel 2 kept on motor speed.
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_MON_SRC, 16'(c << MON_CH1_LSB));
      settle();
      chk_m(probe_ch1_o, exp_mon[c]);
      chk_m(probe_ch2_o, 10'sd511);
    end
    wr(ADDR_MON_SRC, 16'h0000);
    wr(ADDR_CH1_GAIN, 16'h0032);
    settle();
    chk_m(probe_ch1_o, 10'sd255);
    wr(ADDR_CH1_GAIN, 16'h0064);
    // Every analog polarity digit, pulse polarity following its low bit.
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_POLARITY, 16'(p | ((p & 1) << POL_PULSE_BIT)));
      settle();
      chk_m(probe_ch1_o, p[1] ? -10'sd511 : 10'sd511);
      chk_m(probe_ch2_o, p[0] ? -10'sd511 : 10'sd511);
      chk_w({pulse_a_o, pulse_b_o}, p[0] ? 16'h0001 : 16'h0002);
    end
    wr(ADDR_LIMIT_EN, 16'h0010);
    wr(ADDR_MODE_CTRL, 16'h0001);
    wr(ADDR_POS_INDEX, 16'h0005);
    wr(ADDR_POS_DATA, 16'h1234);
    ctrl.drive(1'b0, 6'h05, 2'h2, 2'h1);
    #1 chk_w({torque_mode_o, motor_hold_o}, 16'h0001);
    chk_w(speed_limit_en_o, 16'h0000);
    ctrl.fire();
    #1 chk_w(motor_hold_o, 16'h0000);
    chk_w(position_cmd_o, 16'h1234);
    chk_w(torque_limit_en_o, 16'h0001);
    chk_w(torque_limit_o, 16'h0200);
    chk_w(torque_cmd_o, 16'h0000);
    wr(ADDR_LIMIT_EN, 16'h0000);
    wr(ADDR_MODE_CTRL, 16'h0000);
    settle();
    chk_w(torque_limit_en_o, 16'h0000);
    chk_w(torque_limit_o, 16'h0000);
    chk_w(position_cmd_o, 16'h0ABC);
    // Back to torque mode with speed select 0, so the analog input sets the limit.
    ctrl.drive(1'b1, 6'h05, 2'h0, 2'h0);
    #1 chk_w({torque_mode_o, motor_hold_o}, 16'h0002);
    chk_w(speed_limit_en_o, 16'h0000);
    chk_w(speed_limit_o, 16'h03E8);
    wr(ADDR_MAX_SPEED, 16'h0080);
    settle();
    chk_w(speed_limit_o, 16'h0080);
    results();
  end
endmodule
